// file: verilog/phy_tuning_register_bank.sv
// Module: AHB-Lite register bank of transceiver tuning and delay settings.
//
// Register access over AHB-Lite was decided locally.
`timescale 1ns/1ps
// What this block does
// - Transmit clock delay is bits 7:4, code 0001 is 0.50 ns to 4.00 ns.
// - Receive clock delay is bits 3:0, same encoding as transmit.
// - Both packages reset delays to 0111; small package then loads straps after release.
// - Reserved bits of delay and clock-out registers ignore writes, read zero.
// - Fine gain fields reset to trim; 1000 is no change, 2 percent steps.
// - Second channel gain in bits 11:8, first in 3:0, shared encoding.
// - Swing field drives the channel only while its force bit is set.
// - Force bits reset to zero; C and D swings reset to 10000.
// - Clock-out bit 4 routes internal transmit clock to clock output pin.
module phy_tuning_register_bank
    import phy_tuning_pkg::*;
#(
    parameter logic [15:0] FINE_GAIN_TRIM_AB = 16'h0808, // Trim value.
    parameter logic [15:0] FINE_GAIN_TRIM_CD = 16'h0808, // Trim value.
    parameter logic        LARGE_PACKAGE     = 1'b1      // Package option.
) (
    input  wire logic        CLOCK,            // 20 MHz clock.
    input  wire logic        RST_B,            // Async reset, active low.
    input  wire logic        HSEL,             // Slave select.
    input  wire logic [31:0] HADDR,            // Byte address.
    input  wire logic [1:0]  HTRANS,           // Transfer type.
    input  wire logic        HWRITE,           // Write when high.
    input  wire logic [2:0]  HSIZE,            // Transfer size.
    input  wire logic [31:0] HWDATA,           // Write data.
    input  wire logic        HREADY,           // Bus ready in.
    output logic      [31:0] HRDATA,           // Read data.
    output logic             HREADYOUT,        // Always ready.
    output logic             HRESP,            // Always OKAY.
    input  wire logic [3:0]  STRAP_TX_DELAY,   // Small package strap pins.
    input  wire logic [3:0]  STRAP_RX_DELAY,   // Small package strap pins.
    input  wire logic        INTERNAL_TRANSMIT_CLOCK, // Test clock source.
    input  wire logic        NORMAL_CLOCK_OUT, // Normal clock-out source.
    output logic             CLOCK_OUT,        // Clock output pin.
    output logic      [3:0]  TX_DELAY_CODE,    // Transmit delay select.
    output logic      [3:0]  RX_DELAY_CODE,    // Receive delay select.
    output logic      [15:0] FINE_GAIN_AB,     // Channels B:A gain.
    output logic      [15:0] FINE_GAIN_CD,     // Channels D:C gain.
    output logic      [4:0]  DRIVER_SWING_CHAN_A, // Effective swing.
    output logic      [4:0]  DRIVER_SWING_CHAN_B, // Effective swing.
    output logic      [4:0]  DRIVER_SWING_CHAN_C, // Effective swing.
    output logic      [4:0]  DRIVER_SWING_CHAN_D, // Effective swing.
    output logic      [3:0]  SWING_OVERRIDE,   // Force bits D,C,B,A.
    output logic      [15:0] EQUALIZER_SETTING_WORD, // Equalizer config.
    output logic      [15:0] LOWPASS_SETTING_WORD,   // Low-pass config.
    output logic      [15:0] EQUALIZER_ENABLE_WORD,  // Equalizer enable.
    output logic      [15:0] SYNC_FIFO_WORD,         // Sync FIFO config.
    output logic      [15:0] LOOPBACK_SETTING_WORD   // Loopback config.
);

    typedef struct packed {
        logic        wr_pend;
        logic [7:0]  wr_idx;
        logic        strap_done;
        logic [1:0]  strap_wait;
        logic [7:0]  strap_s1;
        logic [7:0]  strap_s2;
        logic [15:0] clock_delay;
        logic [15:0] rx_eq_config;
        logic [15:0] fine_gain_ab;
        logic [15:0] fine_gain_cd;
        logic [15:0] driver_ab;
        logic [15:0] driver_cd;
        logic [15:0] rx_lowpass;
        logic [15:0] rx_eq_enable;
        logic [15:0] clock_out;
        logic [15:0] sync_fifo;
        logic [15:0] loopback;
        logic [31:0] rdata;
    } state_t;

    // Strap-independent reset image; delays start at 0111 on both packages
    // and the small package loads 00 on the first two edges after release, then the synchronised straps on the third.
    localparam state_t STATE_RESET = '{
        wr_pend:      1'b0,
        wr_idx:       8'h00,
        strap_done:   1'b0,
        strap_wait:   2'h0,
        strap_s1:     8'h00,
        strap_s2:     8'h00,
        clock_delay:  {8'h00, DELAY_RESET_CODE, DELAY_RESET_CODE},
        rx_eq_config: RST_RX_EQ_CONFIG,
        fine_gain_ab: FINE_GAIN_TRIM_AB & MASK_FINE_GAIN,
        fine_gain_cd: FINE_GAIN_TRIM_CD & MASK_FINE_GAIN,
        driver_ab:    RST_DRIVER,
        driver_cd:    RST_DRIVER,
        rx_lowpass:   RST_RX_LOWPASS,
        rx_eq_enable: RST_RX_EQ_ENABLE,
        clock_out:    RST_CLOCK_OUT,
        sync_fifo:    RST_SYNC_FIFO,
        loopback:     RST_LOOPBACK,
        rdata:        32'h0000_0000
    };

    state_t state_reg;
    state_t state_next;

    logic       addr_take;
    logic [7:0] addr_idx;
    logic       addr_ok;

    assign addr_take = HSEL && HREADY && (HTRANS == HTRANS_NONSEQ);
    assign addr_idx  = HADDR[9:2];
    assign addr_ok   = (HADDR[31:10] == 22'h000000) && (HADDR[1:0] == 2'h0);

    function automatic logic [15:0] read_reg(input state_t s,
                                             input logic [7:0] idx);
        logic [15:0] val;
        val = 16'h0000;
        if (idx == IDX_CLOCK_DELAY) begin
            val = s.clock_delay & MASK_CLOCK_DELAY;
        end else if (idx == IDX_RX_EQ_CONFIG) begin
            val = s.rx_eq_config;
        end else if (idx == IDX_FINE_GAIN_AB) begin
            val = s.fine_gain_ab;
        end else if (idx == IDX_FINE_GAIN_CD) begin
            val = s.fine_gain_cd;
        end else if (idx == IDX_DRIVER_AB) begin
            val = s.driver_ab;
        end else if (idx == IDX_DRIVER_CD) begin
            val = s.driver_cd;
        end else if (idx == IDX_RX_LOWPASS) begin
            val = s.rx_lowpass;
        end else if (idx == IDX_RX_EQ_ENABLE) begin
            val = s.rx_eq_enable;
        end else if (idx == IDX_CLOCK_OUT) begin
            val = s.clock_out & MASK_CLOCK_OUT;
        end else if (idx == IDX_SYNC_FIFO) begin
            val = s.sync_fifo;
        end else if (idx == IDX_LOOPBACK) begin
            val = s.loopback;
        end
        return val;
    endfunction

    always_comb begin
        logic [15:0] wd;
        wd = HWDATA[15:0];
        state_next = state_reg;
        state_next.strap_s1 = {STRAP_TX_DELAY, STRAP_RX_DELAY};
        state_next.strap_s2 = state_reg.strap_s1;
        // Straps load once, after both synchroniser stages hold levels
        // taken since release; a delay write landing before then is lost on the small package.
        if (!state_reg.strap_done) begin
            state_next.strap_wait = state_reg.strap_wait + 2'h1;
            state_next.strap_done = (state_reg.strap_wait == 2'h2);
        end
        // Data phase of a write.
        if (state_reg.wr_pend) begin
            if (state_reg.wr_idx == IDX_CLOCK_DELAY) begin
                state_next.clock_delay = wd & MASK_CLOCK_DELAY;
            end else if (state_reg.wr_idx == IDX_RX_EQ_CONFIG) begin
                state_next.rx_eq_config = wd;
            end else if (state_reg.wr_idx == IDX_FINE_GAIN_AB) begin
                state_next.fine_gain_ab = wd & MASK_FINE_GAIN;
            end else if (state_reg.wr_idx == IDX_FINE_GAIN_CD) begin
                state_next.fine_gain_cd = wd & MASK_FINE_GAIN;
            end else if (state_reg.wr_idx == IDX_DRIVER_AB) begin
                state_next.driver_ab = wd & MASK_DRIVER;
            end else if (state_reg.wr_idx == IDX_DRIVER_CD) begin
                state_next.driver_cd = wd & MASK_DRIVER;
            end else if (state_reg.wr_idx == IDX_RX_LOWPASS) begin
                state_next.rx_lowpass = wd;
            end else if (state_reg.wr_idx == IDX_RX_EQ_ENABLE) begin
                state_next.rx_eq_enable = wd;
            end else if (state_reg.wr_idx == IDX_CLOCK_OUT) begin
                state_next.clock_out = wd & MASK_CLOCK_OUT;
            end else if (state_reg.wr_idx == IDX_SYNC_FIFO) begin
                state_next.sync_fifo = wd;
            end else if (state_reg.wr_idx == IDX_LOOPBACK) begin
                state_next.loopback = wd;
            end
        end
        // One-time strap load on the small package; requests are expected
        // from the third edge after release, when the load has been made.
        if (!LARGE_PACKAGE && !state_reg.strap_done) begin
            state_next.clock_delay = {8'h00, state_reg.strap_s2};
        end
        // Address phase.
        state_next.wr_pend = addr_take && HWRITE && addr_ok &&
                             (HSIZE == HSIZE_WORD);
        state_next.wr_idx  = addr_idx;
        if (addr_take && !HWRITE && addr_ok) begin
            state_next.rdata = {16'h0000, read_reg(state_reg, addr_idx)};
        end else if (addr_take) begin
            state_next.rdata = 32'h0000_0000;
        end
    end

    always_ff @(posedge CLOCK or negedge RST_B) begin
        if (!RST_B) begin
            state_reg <= STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    assign HRDATA    = state_reg.rdata;
    assign HREADYOUT = 1'b1;
    assign HRESP     = 1'b0;

    assign TX_DELAY_CODE = state_reg.clock_delay[7:4];
    assign RX_DELAY_CODE = state_reg.clock_delay[3:0];
    assign FINE_GAIN_AB  = state_reg.fine_gain_ab;
    assign FINE_GAIN_CD  = state_reg.fine_gain_cd;
    assign SWING_OVERRIDE = {state_reg.driver_cd[OVERRIDE_HI_BIT],
                             state_reg.driver_cd[OVERRIDE_LO_BIT],
                             state_reg.driver_ab[OVERRIDE_HI_BIT],
                             state_reg.driver_ab[OVERRIDE_LO_BIT]};
    // Without the force bit the analog default swing applies; we present
    // the reset swing so downstream logic always sees a legal code.
    assign DRIVER_SWING_CHAN_A = SWING_OVERRIDE[0] ?
        state_reg.driver_ab[4:0] : RST_DRIVER[4:0];
    assign DRIVER_SWING_CHAN_B = SWING_OVERRIDE[1] ?
        state_reg.driver_ab[12:8] : RST_DRIVER[12:8];
    assign DRIVER_SWING_CHAN_C = SWING_OVERRIDE[2] ?
        state_reg.driver_cd[4:0] : RST_DRIVER[4:0];
    assign DRIVER_SWING_CHAN_D = SWING_OVERRIDE[3] ?
        state_reg.driver_cd[12:8] : RST_DRIVER[12:8];
    assign EQUALIZER_SETTING_WORD = state_reg.rx_eq_config;
    assign LOWPASS_SETTING_WORD   = state_reg.rx_lowpass;
    assign EQUALIZER_ENABLE_WORD  = state_reg.rx_eq_enable;
    assign SYNC_FIFO_WORD         = state_reg.sync_fifo;
    assign LOOPBACK_SETTING_WORD  = state_reg.loopback;
    assign CLOCK_OUT = state_reg.clock_out[TEST_CLOCK_BIT] ?
        INTERNAL_TRANSMIT_CLOCK : NORMAL_CLOCK_OUT;

    // Assertions.
    delay_reserved_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        state_reg.clock_delay[15:8] == 8'h00)
        else $error("Delay reserved bits set.");
    clkout_reserved_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (state_reg.clock_out & ~MASK_CLOCK_OUT) == 16'h0000)
        else $error("Clock-out reserved bits set.");
    delay_write_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        state_reg.wr_pend && state_reg.wr_idx == IDX_CLOCK_DELAY
        |=> TX_DELAY_CODE == $past(HWDATA[7:4]))
        else $error("Transmit delay not written.");
    rx_delay_write_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        state_reg.wr_pend && state_reg.wr_idx == IDX_CLOCK_DELAY
        |=> RX_DELAY_CODE == $past(HWDATA[3:0]))
        else $error("Receive delay not written.");
    gain_mask_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (FINE_GAIN_AB & ~MASK_FINE_GAIN) == 16'h0000)
        else $error("Gain reserved bits set.");
    gain_hold_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        !(state_reg.wr_pend && state_reg.wr_idx == IDX_FINE_GAIN_CD)
        |=> $stable(FINE_GAIN_CD))
        else $error("Gain changed without write.");
    swing_force_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        SWING_OVERRIDE[3] |-> DRIVER_SWING_CHAN_D ==
        state_reg.driver_cd[12:8])
        else $error("Forced swing not applied.");
    swing_default_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        !SWING_OVERRIDE[0] |-> DRIVER_SWING_CHAN_A == 5'h10)
        else $error("Unforced swing wrong.");
    clock_route_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        state_reg.clock_out[TEST_CLOCK_BIT] |->
        CLOCK_OUT == INTERNAL_TRANSMIT_CLOCK)
        else $error("Test clock not routed.");
    loop_hold_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        !(state_reg.wr_pend && state_reg.wr_idx == IDX_LOOPBACK)
        |=> $stable(LOOPBACK_SETTING_WORD))
        else $error("Loopback changed without write.");
    read_back_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        addr_take && !HWRITE && addr_ok && addr_idx == IDX_SYNC_FIFO
        && !state_reg.wr_pend |=> HRDATA[15:0] == SYNC_FIFO_WORD)
        else $error("Read back mismatch.");
    strap_load_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        !LARGE_PACKAGE && !state_reg.strap_done &&
        state_reg.strap_wait == 2'h2
        |=> state_reg.clock_delay[7:0] == $past(state_reg.strap_s2))
        else $error("Strap delays not loaded.");
    gain_write_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        state_reg.wr_pend && state_reg.wr_idx == IDX_FINE_GAIN_AB
        |=> FINE_GAIN_AB == ($past(HWDATA[15:0]) & MASK_FINE_GAIN))
        else $error("Gain not written.");
    gain_cd_mask_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        (FINE_GAIN_CD & ~MASK_FINE_GAIN) == 16'h0000)
        else $error("Gain reserved bits set.");
    driver_mask_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        ((state_reg.driver_ab | state_reg.driver_cd) & ~MASK_DRIVER) ==
        16'h0000)
        else $error("Driver reserved bits set.");
    swing_a_force_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        SWING_OVERRIDE[0] |-> DRIVER_SWING_CHAN_A ==
        state_reg.driver_ab[4:0])
        else $error("Forced swing A not applied.");
    swing_b_force_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        SWING_OVERRIDE[1] |-> DRIVER_SWING_CHAN_B ==
        state_reg.driver_ab[12:8])
        else $error("Forced swing B not applied.");
    swing_b_default_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        !SWING_OVERRIDE[1] |-> DRIVER_SWING_CHAN_B == 5'h10)
        else $error("Unforced swing B wrong.");
    swing_d_default_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        !SWING_OVERRIDE[3] |-> DRIVER_SWING_CHAN_D == 5'h10)
        else $error("Unforced swing D wrong.");
    clock_normal_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        !state_reg.clock_out[TEST_CLOCK_BIT] |->
        CLOCK_OUT == NORMAL_CLOCK_OUT)
        else $error("Normal clock not routed.");
    clock_out_write_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        state_reg.wr_pend && state_reg.wr_idx == IDX_CLOCK_OUT |=>
        state_reg.clock_out[TEST_CLOCK_BIT] == $past(HWDATA[TEST_CLOCK_BIT]))
        else $error("Clock-out select not written.");
    eq_hold_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        !(state_reg.wr_pend && state_reg.wr_idx == IDX_RX_EQ_CONFIG)
        |=> $stable(EQUALIZER_SETTING_WORD))
        else $error("Equalizer word changed without write.");
    loop_write_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        state_reg.wr_pend && state_reg.wr_idx == IDX_LOOPBACK
        |=> LOOPBACK_SETTING_WORD == $past(HWDATA[15:0]))
        else $error("Loopback word not written.");
    bad_addr_read_a: assert property (
        @(posedge CLOCK) disable iff (!RST_B)
        addr_take && !HWRITE && !addr_ok
        |=> HRDATA == 32'h0000_0000)
        else $error("Bad address read not zero.");
    write_seen_c: cover property (@(posedge CLOCK) disable iff (!RST_B)
        state_reg.wr_pend && state_reg.wr_idx == IDX_CLOCK_DELAY);
    read_seen_c: cover property (@(posedge CLOCK) disable iff (!RST_B)
        addr_take && !HWRITE);
    test_clock_c: cover property (@(posedge CLOCK) disable iff (!RST_B)
        state_reg.clock_out[TEST_CLOCK_BIT]);
    strap_load_c: cover property (@(posedge CLOCK) disable iff (!RST_B)
        !LARGE_PACKAGE && $rose(state_reg.strap_done));
    bad_addr_c: cover property (@(posedge CLOCK) disable iff (!RST_B)
        addr_take && !addr_ok);

endmodule // phy_tuning_register_bank

// file: pkg/phy_tuning_pkg.sv
// Package: register indices, field positions and reset values of the tuning bank.
package phy_tuning_pkg;
    localparam int          REG_INDEX_W        = 8;
    // Printed offsets are register indices; byte address is four times that.
    localparam logic [7:0]  IDX_CLOCK_DELAY    = 8'h86;
    localparam logic [7:0]  IDX_RX_EQ_CONFIG   = 8'h8A;
    localparam logic [7:0]  IDX_FINE_GAIN_AB   = 8'hA0;
    localparam logic [7:0]  IDX_FINE_GAIN_CD   = 8'hA1;
    localparam logic [7:0]  IDX_DRIVER_AB      = 8'hA2;
    localparam logic [7:0]  IDX_DRIVER_CD      = 8'hA3;
    localparam logic [7:0]  IDX_RX_LOWPASS     = 8'hB3;
    localparam logic [7:0]  IDX_RX_EQ_ENABLE   = 8'hC0;
    localparam logic [7:0]  IDX_CLOCK_OUT      = 8'hC6;
    localparam logic [7:0]  IDX_SYNC_FIFO      = 8'hE9;
    localparam logic [7:0]  IDX_LOOPBACK       = 8'hFE;
    // Writable bit masks; all other bits ignore writes and read zero.
    localparam logic [15:0] MASK_CLOCK_DELAY   = 16'h00FF;
    localparam logic [15:0] MASK_FINE_GAIN     = 16'h0F0F;
    localparam logic [15:0] MASK_DRIVER        = 16'h3F3F;
    localparam logic [15:0] MASK_CLOCK_OUT     = 16'h0010;
    localparam int          TEST_CLOCK_BIT     = 4;
    localparam int          OVERRIDE_HI_BIT    = 13;
    localparam int          OVERRIDE_LO_BIT    = 5;
    // Reset values.
    localparam logic [3:0]  DELAY_RESET_CODE   = 4'h7;
    localparam logic [15:0] RST_RX_EQ_CONFIG   = 16'h0000;
    localparam logic [15:0] RST_DRIVER         = 16'h1010;
    localparam logic [15:0] RST_CLOCK_OUT      = 16'h0000;
    localparam logic [15:0] RST_SYNC_FIFO      = 16'h9F22;
    localparam logic [15:0] RST_LOOPBACK       = 16'h0001;
    localparam logic [15:0] RST_RX_LOWPASS     = 16'h0000;
    localparam logic [15:0] RST_RX_EQ_ENABLE   = 16'h0000;
    localparam logic [1:0]  HTRANS_NONSEQ      = 2'h2;
    localparam logic [2:0]  HSIZE_WORD         = 3'h2;
endpackage

// file: testbench/phy_tuning_register_bank_tb.sv
// Self-checking bench for the tuning register bank over AHB-Lite.
`timescale 1ns/1ps
module phy_tuning_register_bank_tb;
    import phy_tuning_pkg::*;
    // Trim values are arbitrary, chosen to differ from the design default.
    localparam logic [15:0] TRIM_AB = 16'h0A05;
    localparam logic [15:0] TRIM_CD = 16'h030C;
    logic        CLOCK    = 1'b0;
    logic        RST_B    = 1'b0;
    logic        HSEL     = 1'b0;
    logic [31:0] HADDR    = 32'h0;
    logic [1:0]  HTRANS   = 2'h0;
    logic        HWRITE   = 1'b0;
    logic [2:0]  HSIZE    = 3'h2;
    logic [31:0] HWDATA   = 32'h0;
    logic [3:0]  STRAP_TX = 4'h0;
    logic [3:0]  STRAP_RX = 4'h0;
    logic        INT_CLK  = 1'b0;
    logic        NORM_CLK = 1'b0;
    logic [31:0] HRDATA;
    logic        HREADYOUT;
    logic        CLOCK_OUT;
    logic [3:0]  TX_DELAY_CODE, RX_DELAY_CODE, SWING_OVERRIDE;
    logic [15:0] FINE_GAIN_AB, FINE_GAIN_CD, EQ_WORD, LPF_WORD, EN_WORD;
    logic [15:0] SYNC_WORD, LOOP_WORD;
    logic [4:0]  SW_A, SW_B, SW_C, SW_D;
    logic [3:0]  TX_SMALL, RX_SMALL;
    logic        HRESP;
    logic [7:0]  sdly = 8'h00;
    logic [7:0]  idx   [11] = '{IDX_CLOCK_DELAY, IDX_RX_EQ_CONFIG,
        IDX_FINE_GAIN_AB, IDX_FINE_GAIN_CD, IDX_DRIVER_AB, IDX_DRIVER_CD,
        IDX_RX_LOWPASS, IDX_RX_EQ_ENABLE, IDX_CLOCK_OUT, IDX_SYNC_FIFO,
        IDX_LOOPBACK};
    logic [15:0] msk   [11] = '{16'h00FF, 16'hFFFF, 16'h0F0F, 16'h0F0F,
        16'h3F3F, 16'h3F3F, 16'hFFFF, 16'hFFFF, 16'h0010, 16'hFFFF, 16'hFFFF};
    logic [15:0] rst_v [11] = '{16'h0077, 16'h0000, TRIM_AB, TRIM_CD,
        16'h1010, 16'h1010, 16'h0000, 16'h0000, 16'h0000, 16'h9F22, 16'h0001};
    logic [15:0] wv    [11];
    logic [15:0] exp_q [$];
    logic        rd_phase = 1'b0;
    logic [31:0] seed     = 32'd77;
    logic [31:0] r;
    logic [15:0] v;
    int          miscompares = 0;
    int          check_count = 0;

    phy_tuning_register_bank #(
        .FINE_GAIN_TRIM_AB (TRIM_AB),
        .FINE_GAIN_TRIM_CD (TRIM_CD),
        .LARGE_PACKAGE     (1'b1)
    ) u_dut (
        .CLOCK (CLOCK), .RST_B (RST_B), .HSEL (HSEL), .HADDR (HADDR),
        .HTRANS (HTRANS), .HWRITE (HWRITE), .HSIZE (HSIZE),
        .HWDATA (HWDATA), .HREADY (HREADYOUT), .HRDATA (HRDATA),
        .HREADYOUT (HREADYOUT), .HRESP (HRESP), .STRAP_TX_DELAY (STRAP_TX),
        .STRAP_RX_DELAY (STRAP_RX), .INTERNAL_TRANSMIT_CLOCK (INT_CLK),
        .NORMAL_CLOCK_OUT (NORM_CLK), .CLOCK_OUT (CLOCK_OUT),
        .TX_DELAY_CODE (TX_DELAY_CODE), .RX_DELAY_CODE (RX_DELAY_CODE),
        .FINE_GAIN_AB (FINE_GAIN_AB), .FINE_GAIN_CD (FINE_GAIN_CD),
        .DRIVER_SWING_CHAN_A (SW_A), .DRIVER_SWING_CHAN_B (SW_B),
        .DRIVER_SWING_CHAN_C (SW_C), .DRIVER_SWING_CHAN_D (SW_D),
        .SWING_OVERRIDE (SWING_OVERRIDE), .EQUALIZER_SETTING_WORD (EQ_WORD),
        .LOWPASS_SETTING_WORD (LPF_WORD), .EQUALIZER_ENABLE_WORD (EN_WORD),
        .SYNC_FIFO_WORD (SYNC_WORD), .LOOPBACK_SETTING_WORD (LOOP_WORD)
    );

    // Small-package variant on the same bus; only its delay codes are
    // watched, to prove the strap load and later writes.
    phy_tuning_register_bank #(
        .FINE_GAIN_TRIM_AB (TRIM_AB),
        .FINE_GAIN_TRIM_CD (TRIM_CD),
        .LARGE_PACKAGE     (1'b0)
    ) u_dut_small (
        .CLOCK (CLOCK), .RST_B (RST_B), .HSEL (HSEL), .HADDR (HADDR),
        .HTRANS (HTRANS), .HWRITE (HWRITE), .HSIZE (HSIZE),
        .HWDATA (HWDATA), .HREADY (HREADYOUT), .HRDATA (),
        .HREADYOUT (), .HRESP (), .STRAP_TX_DELAY (STRAP_TX),
        .STRAP_RX_DELAY (STRAP_RX), .INTERNAL_TRANSMIT_CLOCK (INT_CLK),
        .NORMAL_CLOCK_OUT (NORM_CLK), .CLOCK_OUT (),
        .TX_DELAY_CODE (TX_SMALL), .RX_DELAY_CODE (RX_SMALL),
        .FINE_GAIN_AB (), .FINE_GAIN_CD (), .DRIVER_SWING_CHAN_A (),
        .DRIVER_SWING_CHAN_B (), .DRIVER_SWING_CHAN_C (),
        .DRIVER_SWING_CHAN_D (), .SWING_OVERRIDE (),
        .EQUALIZER_SETTING_WORD (), .LOWPASS_SETTING_WORD (),
        .EQUALIZER_ENABLE_WORD (), .SYNC_FIFO_WORD (),
        .LOOPBACK_SETTING_WORD ()
    );

    initial begin
        forever #25 CLOCK = ~CLOCK;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] addr(input int i);
        return {22'h0, idx[i], 2'h0};
    endfunction

    function automatic logic [31:0] swing(input logic f, input logic [4:0] s);
        return f ? {27'h0, s} : 32'h10;
    endfunction

    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        check_count++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic end_sim();
        if (miscompares == 0 && check_count > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    // Unrelated strap and clock-source inputs are scrambled on every
    // transfer so that the clock-out mux sees both sources toggle.
    task automatic xfer(input logic w, input logic [31:0] a,
                        input logic [15:0] d);
        logic [31:0] q;
        q = xs();
        HSEL   <= 1'b1;
        HADDR  <= a;
        HTRANS <= HTRANS_NONSEQ;
        HWRITE <= w;
        HSIZE  <= HSIZE_WORD;
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
        HTRANS   <= 2'h0;
        HWDATA   <= {q[31:16], d};
        INT_CLK  <= q[0];
        NORM_CLK <= q[1];
        STRAP_TX <= q[5:2];
        STRAP_RX <= q[9:6];
        if (!w) begin
            exp_q.push_back(d);
        end
        do @(posedge CLOCK); while (HREADYOUT !== 1'b1);
    endtask

    always @(posedge CLOCK) begin
        if (rd_phase) begin
            check(32'(HRESP), 32'h0);
            if (exp_q.size() == 0) begin
                miscompares++;
            end else begin
                check(HRDATA, {16'h0, exp_q.pop_front()});
            end
        end
        rd_phase <= HSEL && (HTRANS == HTRANS_NONSEQ) && !HWRITE && HREADYOUT;
    end

    task automatic check_all();
        for (int i = 0; i < 11; i++) begin
            xfer(1'b0, addr(i), wv[i]);
        end
        #1;
        check(32'(TX_DELAY_CODE), 32'(wv[0][7:4]));
        check(32'(RX_DELAY_CODE), 32'(wv[0][3:0]));
        check({FINE_GAIN_AB, FINE_GAIN_CD}, {wv[2], wv[3]});
        check(32'(SWING_OVERRIDE),
              32'({wv[5][13], wv[5][5], wv[4][13], wv[4][5]}));
        check(32'(SW_A), swing(wv[4][5], wv[4][4:0]));
        check(32'(SW_B), swing(wv[4][13], wv[4][12:8]));
        check(32'(SW_C), swing(wv[5][5], wv[5][4:0]));
        check(32'(SW_D), swing(wv[5][13], wv[5][12:8]));
        check({EQ_WORD, LPF_WORD}, {wv[1], wv[6]});
        check({EN_WORD, LOOP_WORD}, {wv[7], wv[10]});
        check(32'(SYNC_WORD), 32'(wv[9]));
        check(32'({TX_SMALL, RX_SMALL}), 32'(sdly));
        check(32'(CLOCK_OUT), 32'(wv[8][4] ? INT_CLK : NORM_CLK));
        @(posedge CLOCK);
    endtask

    // Straps take fresh random levels and hold them through reset, so the
    // small-package variant must load exactly these.
    task automatic do_reset();
        r = xs();
        RST_B    <= 1'b0;
        STRAP_TX <= r[3:0];
        STRAP_RX <= r[7:4];
        repeat (20) @(posedge CLOCK);
        RST_B <= 1'b1;
        @(posedge CLOCK);
        wv   = rst_v;
        sdly = {STRAP_TX, STRAP_RX};
    endtask

    initial begin
        do_reset();
        check_all();
        for (int p = 0; p < 5; p++) begin
            for (int i = 0; i < 11; i++) begin
                r = xs();
                v = (p == 0) ? 16'hFFFF : (p == 1) ? 16'h0000 : r[15:0];
                xfer(1'b1, addr(i), v);
                wv[i] = v & msk[i];
                if (i == 0) begin
                    sdly = v[7:0];
                end
            end
            check_all();
        end
        xfer(1'b1, addr(1), 16'h010F);
        xfer(1'b1, addr(6), 16'h000C);
        xfer(1'b1, addr(7), 16'h0000);
        xfer(1'b1, addr(10), 16'hE720);
        wv[1]  = 16'h010F;
        wv[6]  = 16'h000C;
        wv[7]  = 16'h0000;
        wv[10] = 16'hE720;
        // Unmapped index and stray high address bits must leave all intact.
        xfer(1'b1, 32'h0000_021C, 16'h1234);
        xfer(1'b0, 32'h0000_021C, 16'h0000);
        xfer(1'b1, 32'h0001_0000 | addr(10), 16'h5555);
        xfer(1'b0, 32'h0001_0000 | addr(10), 16'h0000);
        check_all();
        do_reset();
        check_all();
        end_sim();
    end

    initial begin
        repeat (5000) @(posedge CLOCK);
        miscompares++;
        end_sim();
    end
endmodule // phy_tuning_register_bank_tb
